// >>> verilog/spp_cfg.svh
// Constants of the serial peripheral port: field positions, resets, counts.
`ifndef SPP_CFG_SVH
`define SPP_CFG_SVH

// Field positions inside the port control word.
`define SPP_CTL_EN_BIT       0
`define SPP_CTL_MASTER_BIT   1
`define SPP_CTL_CPOL_BIT     2
`define SPP_CTL_CPHA_BIT     3
`define SPP_CTL_OD_BIT       4
`define SPP_CTL_SOD_BIT      5
`define SPP_CTL_DIV_LSB      6
`define SPP_CTL_WIDTH        14

// Word length and the number of serial clock edges in one word.
`define SPP_WORD_BITS        8
`define SPP_LAST_EDGE        4'hf
`define SPP_EDGE_TOTAL       5'h10

// Transmit buffer depth in words.
`define SPP_FIFO_DEPTH       4

// Boot configuration code that selects serial master boot.
`define SPP_BOOT_SPI_MASTER  2'h1

// Pin levels driven during reset in serial master boot.
`define SPP_BOOT_SCLK_LEVEL  1'h0
`define SPP_BOOT_MOSI_LEVEL  1'h1

// Reset values of internal state.
`define SPP_RST_WORD         8'h00
`define SPP_RST_EDGE         4'h0
`define SPP_RST_DIV          8'h00

`endif

// >>> verilog/spp_pkg.sv
// Types shared by the serial peripheral port design.
`default_nettype none
package spp_pkg;

    // Transfer sequencer states.
    typedef enum logic [1:0] {
        SPP_IDLE = 2'b00,
        SPP_XFER = 2'b01,
        SPP_DONE = 2'b10
    } spp_state_e;

    // One serial word.
    typedef logic [7:0] spp_word_t;

    // Port control word, bit 0 at the bottom.
    typedef struct packed {
        logic [7:0] clk_div;           // Half period of the clock minus one.
        logic       slave_out_disable; // Bit 5: release the slave-out pin.
        logic       open_drain_sel;    // Bit 4: slave-out drives low only.
        logic       cpha;
        logic       cpol;
        logic       master;
        logic       enable;
    } spp_ctrl_s;

    // Output level and enable of one two-way pin; oe_n low means driving.
    typedef struct packed {
        logic out;
        logic oe_n;
    } spp_pin_s;

endpackage : spp_pkg
`default_nettype wire

// >>> verilog/spp_fifo.sv
// Small first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module spp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset.
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    // Filling side.
    input  wire logic             i_wr_valid,
    input  wire logic [WIDTH-1:0] i_wr_data,
    output logic                  o_wr_ready,
    // Draining side.
    output logic                  o_rd_valid,
    output logic [WIDTH-1:0]      o_rd_data,
    input  wire logic             i_rd_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    logic             push;
    logic             pop;

    // Full and empty come straight from the occupancy count.
    assign o_wr_ready = (count_ff != (AW+1)'(DEPTH));
    assign o_rd_valid = (count_ff != '0);
    assign o_rd_data  = mem_ff[rd_ptr_ff];
    assign push       = i_wr_valid && o_wr_ready;
    assign pop        = o_rd_valid && i_rd_ready;

    // Storage carries no reset; only the pointers define what is valid.
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= i_wr_data;
        end
    end

    // Pointers wrap at the depth, which is a power of two.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + AW'(1);
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + AW'(1);
            end
            count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : spp_fifo
`default_nettype wire

// >>> verilog/spp_port.sv
// Serial peripheral port: master and slave roles, pin directions, drive modes.
`timescale 1ns/1ps
`default_nettype none
`include "spp_cfg.svh"

// What this block does
// - As master the port makes the serial clock; its rate sets bit rate.
// - One serial clock cycle per bit, toggling only during a word.
// - Serial clock runs only for the word length, idle otherwise.
// - A slave ignores the serial clock while slave select is high.
// - Data is launched on one clock edge and sampled on the other.
// - Clock polarity and phase are programmable and pick the format.
// - In serial master boot, master-out and clock are driven in reset.
// - Slave select is active low and acts as a chip select.
// - Slave select low while master is flagged as a multimaster error.
// - Master-out transmits as master and receives as slave.
// - Slave-out receives as master and transmits as slave.
// - The open-drain bit makes slave-out drive low only.
// - Control bit 5 disables the slave-out output for broadcasts.
module spp_port (
    // Clock and reset.
    input  wire logic              i_clk_sys,
    input  wire logic              i_resetn,
    // Port control word and boot straps.
    input  wire spp_pkg::spp_ctrl_s i_port_control_reg,
    input  wire logic [1:0]        i_boot_config_pins,
    // Serial clock pin.
    input  wire logic              i_serial_clock_pin,
    output logic                   o_serial_clock_pin,
    output logic                   o_serial_clock_pin_oe_n,
    // Master-out slave-in pin.
    input  wire logic              i_mosi,
    output logic                   o_mosi,
    output logic                   o_mosi_oe_n,
    // Master-in slave-out pin.
    input  wire logic              i_miso,
    output logic                   o_miso,
    output logic                   o_miso_oe_n,
    // Slave select, active low.
    input  wire logic              i_slave_select_in_n,
    // Transmit words from the user.
    input  wire logic              i_tx_valid,
    input  wire spp_pkg::spp_word_t i_tx_data,
    output logic                   o_tx_ready,
    // Received words to the user.
    output logic                   o_rx_valid,
    output spp_pkg::spp_word_t     o_rx_data,
    // Status.
    output logic                   o_busy,
    output logic                   o_mm_error,
    input  wire logic              i_mm_error_clr
);
    spp_pkg::spp_ctrl_s  ctl;
    spp_pkg::spp_state_e state_ff;
    spp_pkg::spp_word_t  tx_sh_ff;
    spp_pkg::spp_word_t  rx_sh_ff;
    spp_pkg::spp_word_t  rx_data_ff;
    spp_pkg::spp_word_t  fifo_data;
    logic       rst_meta_ff;
    logic       rst_n_ff;
    logic [1:0] boot_meta_ff;
    logic [1:0] boot_sync_ff;
    logic       sclk_meta_ff;
    logic       sclk_sync_ff;
    logic       sclk_prev_ff;
    logic       ss_meta_ff;
    logic       ss_sync_ff;
    logic       mosi_meta_ff;
    logic       mosi_sync_ff;
    logic       miso_meta_ff;
    logic       miso_sync_ff;
    logic       sclk_ff;
    logic [7:0] div_ff;
    logic [3:0] edge_ff;
    logic       rx_valid_ff;
    logic       mm_err_ff;
    logic       fifo_valid;
    logic       fifo_pop;
    logic       is_master;
    logic       is_slave;
    logic       tick;
    logic       ev;
    logic       lead;
    logic       launch;
    logic       sample;
    logic       start;
    logic       abort;
    logic       rx_bit;
    logic       boot_spi;

    assign ctl       = i_port_control_reg;
    assign is_master = ctl.enable && ctl.master;
    assign is_slave  = ctl.enable && !ctl.master;
    assign boot_spi  = (boot_sync_ff == `SPP_BOOT_SPI_MASTER);

    // Reset is asserted at once and released through two flip-flops.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // Boot straps are synchronised without reset so that their level is
    // already known while reset is held; the straps must settle first.
    always_ff @(posedge i_clk_sys) begin
        boot_meta_ff <= i_boot_config_pins;
        boot_sync_ff <= boot_meta_ff;
    end

    // Every pin input passes two flip-flops before any logic looks at it.
    always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            sclk_meta_ff <= 1'b0;
            sclk_sync_ff <= 1'b0;
            sclk_prev_ff <= 1'b0;
            ss_meta_ff   <= 1'b1;
            ss_sync_ff   <= 1'b1;
            mosi_meta_ff <= 1'b0;
            mosi_sync_ff <= 1'b0;
            miso_meta_ff <= 1'b0;
            miso_sync_ff <= 1'b0;
        end else begin
            sclk_meta_ff <= i_serial_clock_pin;
            sclk_sync_ff <= sclk_meta_ff;
            sclk_prev_ff <= sclk_sync_ff;
            ss_meta_ff   <= i_slave_select_in_n;
            ss_sync_ff   <= ss_meta_ff;
            mosi_meta_ff <= i_mosi;
            mosi_sync_ff <= mosi_meta_ff;
            miso_meta_ff <= i_miso;
            miso_sync_ff <= miso_meta_ff;
        end
    end

    // Transmit words wait here; a stalled shifter back-pressures the user.
    spp_fifo #(
        .WIDTH (`SPP_WORD_BITS),
        .DEPTH (`SPP_FIFO_DEPTH)
    ) u_tx_fifo (
        .i_clk      (i_clk_sys),
        .i_rst_n    (rst_n_ff),
        .i_wr_valid (i_tx_valid),
        .i_wr_data  (i_tx_data),
        .o_wr_ready (o_tx_ready),
        .o_rd_valid (fifo_valid),
        .o_rd_data  (fifo_data),
        .i_rd_ready (fifo_pop)
    );

    // Master starts only with a word queued; a selected slave starts at
    // once and sends zeros when the queue is empty.
    assign start = (state_ff == spp_pkg::SPP_IDLE)
                   && ((is_master && fifo_valid && !mm_err_ff)
                       || (is_slave && !ss_sync_ff));
    assign fifo_pop = start && fifo_valid;
    assign abort = is_master ? mm_err_ff : (!is_slave || ss_sync_ff);

    // Master divider: one tick per half period of the serial clock.
    assign tick = (div_ff == ctl.clk_div);
    always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            div_ff <= `SPP_RST_DIV;
        end else if (state_ff != spp_pkg::SPP_XFER || tick) begin
            div_ff <= `SPP_RST_DIV;
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end

    // Edge events: own ticks as master, seen pin edges as slave. The
    // even edges of a word are leading, the odd ones trailing.
    assign ev     = (state_ff == spp_pkg::SPP_XFER)
                    && (is_master ? tick
                                  : (sclk_sync_ff ^ sclk_prev_ff));
    assign lead   = !edge_ff[0];
    assign sample = ev && (lead != ctl.cpha);
    assign launch = ev && (lead == ctl.cpha) && (edge_ff != `SPP_RST_EDGE);
    assign rx_bit = is_master ? miso_sync_ff : mosi_sync_ff;

    // Transfer sequencer shared by both roles.
    always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            state_ff <= spp_pkg::SPP_IDLE;
            edge_ff  <= `SPP_RST_EDGE;
        end else begin
            case (state_ff)
                spp_pkg::SPP_IDLE: begin
                    edge_ff <= `SPP_RST_EDGE;
                    if (start) begin
                        state_ff <= spp_pkg::SPP_XFER;
                    end
                end
                spp_pkg::SPP_XFER: begin
                    if (abort) begin
                        state_ff <= spp_pkg::SPP_IDLE;
                    end else if (ev) begin
                        edge_ff <= edge_ff + 4'h1;
                        if (edge_ff == `SPP_LAST_EDGE) begin
                            state_ff <= spp_pkg::SPP_DONE;
                        end
                    end
                end
                spp_pkg::SPP_DONE: begin
                    state_ff <= spp_pkg::SPP_IDLE;
                end
                default: begin
                    state_ff <= spp_pkg::SPP_IDLE;
                end
            endcase
        end
    end

    // Shift registers: bit 7 leaves first, received bits enter at bit 0.
    always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            tx_sh_ff <= `SPP_RST_WORD;
            rx_sh_ff <= `SPP_RST_WORD;
        end else if (start) begin
            tx_sh_ff <= fifo_valid ? fifo_data : `SPP_RST_WORD;
        end else begin
            if (launch) begin
                tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
            end
            if (sample) begin
                rx_sh_ff <= {rx_sh_ff[6:0], rx_bit};
            end
        end
    end

    // Master serial clock rests at the polarity level between words and
    // toggles once per tick during one, sixteen times per word.
    always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            sclk_ff <= `SPP_BOOT_SCLK_LEVEL;
        end else if (state_ff != spp_pkg::SPP_XFER || !is_master) begin
            sclk_ff <= ctl.cpol;
        end else if (tick) begin
            sclk_ff <= !sclk_ff;
        end
    end

    // Received word and its one-cycle valid pulse; no back-pressure here,
    // so the user must take every word as it comes.
    always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            rx_data_ff  <= `SPP_RST_WORD;
            rx_valid_ff <= 1'b0;
        end else begin
            rx_valid_ff <= (state_ff == spp_pkg::SPP_DONE);
            if (state_ff == spp_pkg::SPP_DONE) begin
                rx_data_ff <= rx_sh_ff;
            end
        end
    end

    // Multimaster error is sticky; a new detection wins over the clear.
    always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            mm_err_ff <= 1'b0;
        end else if (is_master && !ss_sync_ff) begin
            mm_err_ff <= 1'b1;
        end else if (i_mm_error_clr) begin
            mm_err_ff <= 1'b0;
        end
    end

    // Pin drivers. During reset only serial master boot drives the clock
    // and master-out; otherwise the role chooses each pin's direction.
    always_comb begin
        o_serial_clock_pin      = sclk_ff;
        o_serial_clock_pin_oe_n = 1'b1;
        o_mosi                  = tx_sh_ff[7];
        o_mosi_oe_n             = 1'b1;
        o_miso                  = tx_sh_ff[7];
        o_miso_oe_n             = 1'b1;
        if (!rst_n_ff) begin
            o_serial_clock_pin      = `SPP_BOOT_SCLK_LEVEL;
            o_mosi                  = `SPP_BOOT_MOSI_LEVEL;
            o_serial_clock_pin_oe_n = !boot_spi;
            o_mosi_oe_n             = !boot_spi;
        end else if (is_master && !mm_err_ff) begin
            o_serial_clock_pin_oe_n = 1'b0;
            o_mosi_oe_n             = 1'b0;
        end else if (is_slave && !ss_sync_ff && !ctl.slave_out_disable) begin
            if (ctl.open_drain_sel) begin
                o_miso      = 1'b0;
                o_miso_oe_n = tx_sh_ff[7];
            end else begin
                o_miso_oe_n = 1'b0;
            end
        end
    end

    // Status and received data outputs.
    assign o_rx_valid = rx_valid_ff;
    assign o_rx_data  = rx_data_ff;
    assign o_mm_error = mm_err_ff;
    assign o_busy     = (state_ff != spp_pkg::SPP_IDLE);

    // Counts master clock toggles within one word.
    logic [4:0] tog_cnt_ff;
    always_ff @(posedge i_clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            tog_cnt_ff <= 5'h00;
        end else if (state_ff == spp_pkg::SPP_IDLE) begin
            tog_cnt_ff <= 5'h00;
        end else if (is_master && tick && state_ff == spp_pkg::SPP_XFER) begin
            tog_cnt_ff <= tog_cnt_ff + 5'h01;
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!rst_n_ff);

    a_word_toggles: assert property (
        (is_master && state_ff == spp_pkg::SPP_DONE)
        |-> tog_cnt_ff == `SPP_EDGE_TOTAL)
        else $error("Master word did not have sixteen clock edges.");
    a_clock_idle: assert property (
        (state_ff == spp_pkg::SPP_IDLE && $past(state_ff) == spp_pkg::SPP_IDLE
         && $stable(ctl.cpol)) |-> sclk_ff == ctl.cpol)
        else $error("Serial clock not at rest level between words.");
    a_slave_deselect: assert property (
        (is_slave && ss_sync_ff && state_ff == spp_pkg::SPP_XFER)
        |=> state_ff == spp_pkg::SPP_IDLE)
        else $error("Slave kept shifting while deselected.");
    a_launch_edge: assert property (
        ($changed(tx_sh_ff) && $past(state_ff) == spp_pkg::SPP_XFER)
        |-> $past(launch))
        else $error("Transmit data moved off its launch edge.");
    a_clock_rate: assert property (
        (is_master && state_ff == spp_pkg::SPP_XFER && $rose(sclk_ff)
         && ctl.clk_div == 8'h03 && $stable(ctl))
        |-> ##1 $stable(sclk_ff) [*3])
        else $error("Serial clock half period shorter than programmed.");
    a_boot_drive: assert property (@(posedge i_clk_sys) disable iff (1'b0)
        (!rst_n_ff && boot_spi)
        |-> (!o_serial_clock_pin_oe_n && !o_mosi_oe_n))
        else $error("Boot master pins released during reset.");
    a_mm_detect: assert property (
        (is_master && !ss_sync_ff) |=> mm_err_ff [*2])
        else $error("Multimaster error not flagged.");
    a_mosi_dir: assert property (
        is_master ? (o_mosi_oe_n == mm_err_ff) : o_mosi_oe_n)
        else $error("Master-out direction wrong for the role.");
    a_miso_dir: assert property (
        is_master |-> o_miso_oe_n)
        else $error("Slave-out driven while master.");
    a_open_drain: assert property (
        (ctl.open_drain_sel && !o_miso_oe_n) |-> !o_miso)
        else $error("Open-drain slave-out drove high.");
    a_miso_off: assert property (
        ctl.slave_out_disable |-> o_miso_oe_n)
        else $error("Disabled slave-out still driven.");
    a_miso_on: assert property (
        (is_slave && !ss_sync_ff && !ctl.slave_out_disable
         && !ctl.open_drain_sel) |-> !o_miso_oe_n)
        else $error("Selected slave did not drive slave-out.");

    c_master_word: cover property (is_master && o_rx_valid);
    c_slave_word: cover property (is_slave && o_rx_valid);
    c_mm_error: cover property ($rose(mm_err_ff));
    c_fifo_full: cover property (!o_tx_ready && is_master);
endmodule : spp_port
`default_nettype wire

// >>> verification/spp_peer.sv
// Far-side party of the serial port: a slave that answers, or a master.
`timescale 1ns/1ps
`default_nettype none
module spp_peer (
    // Resolved pin levels and the format in use.
    input  wire logic i_sclk,
    input  wire logic i_mosi,
    input  wire logic i_miso,
    input  wire logic i_cpol,
    input  wire logic i_cpha,
    // Drives of this party; a line with its enable low is released.
    output logic      o_miso,
    output logic      o_miso_en,
    output logic      o_sclk,
    output logic      o_sclk_en,
    output logic      o_mosi,
    output logic      o_mosi_en,
    output logic      o_ss_n
);
    logic [7:0] sr;
    logic [7:0] rx;
    logic       started;

    // At rest nothing is driven and the port's select stays high.
    initial begin
        {sr, rx, started, o_sclk, o_sclk_en, o_mosi, o_mosi_en} = '0;
        o_miso_en = 1'b0;
        o_ss_n    = 1'b1;
    end
    assign o_miso = sr[7];

    // Slave role; unarmed it ignores the clock and leaves the line free.
    always @(i_sclk) begin
        if (o_miso_en) begin
            if (i_sclk == ~(i_cpol ^ i_cpha)) begin
                rx = {rx[6:0], i_mosi};
            end else begin
                if (!i_cpha || started) begin
                    sr = {sr[6:0], 1'b0};
                end
                started = 1'b1;
            end
        end
    end

    task automatic arm(input logic [7:0] tx);
        sr        = tx;
        rx        = 8'h00;
        started   = 1'b0;
        o_miso_en = 1'b1;
    endtask : arm

    task automatic disarm();
        o_miso_en = 1'b0;
    endtask : disarm

    // Offset keeps our edges clear of the system clock's edges.
    task automatic sel(input logic lvl);
        #1.3;
        o_ss_n = lvl;
    endtask : sel

    // Master role, format 0; the clock then stands low between frames.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] got);
        got = 8'h00;
        #1.3;
        o_sclk    = 1'b0;
        o_sclk_en = 1'b1;
        o_mosi_en = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            o_mosi = tx[i];
            #62.5 o_sclk = 1'b1;
            got = {got[6:0], i_miso};
            #62.5 o_sclk = 1'b0;
        end
        o_mosi_en = 1'b0;
    endtask : xfer
endmodule : spp_peer
`default_nettype wire

// >>> verification/spp_port_tb.sv
// Self-checking bench of the serial port against the far-side model.
`timescale 1ns/1ps
`default_nettype none
module spp_port_tb;
    logic               i_clk_sys, i_resetn, tx_valid, clr, exp_oe;
    spp_pkg::spp_ctrl_s ctrl;
    logic [1:0]         boot;
    spp_pkg::spp_word_t tx_data, rx_data, got;
    logic sclk_o, sclk_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
    logic tx_ready, rx_valid, busy, mm_err, ss_n;
    logic p_miso, p_miso_en, p_sclk, p_sclk_en, p_mosi, p_mosi_en;
    int   fails, tests_run, cycles, edges, rxcnt;
    spp_pkg::spp_word_t mw [4] = '{8'hA5, 8'h3C, 8'h81, 8'h5E};
    spp_pkg::spp_word_t sw [3] = '{8'h69, 8'hB5, 8'h4B};
    logic [2:0]         od = 3'b010;
    logic [2:0]         sod = 3'b100;

    // Wire levels: a driving party wins, a released line is pulled high.
    wire logic sclk_w = !sclk_oe_n ? sclk_o : p_sclk_en ? p_sclk : 1'b1;
    wire logic mosi_w = !mosi_oe_n ? mosi_o : p_mosi_en ? p_mosi : 1'b1;
    wire logic miso_w = !miso_oe_n ? miso_o : p_miso_en ? p_miso : 1'b1;
    wire logic [7:0] pins = {3'h0, sclk_oe_n, sclk_o, mosi_oe_n, mosi_o,
                             miso_oe_n};

    spp_port spp_port_inst (
        .i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
        .i_port_control_reg(ctrl), .i_boot_config_pins(boot),
        .i_serial_clock_pin(sclk_w), .o_serial_clock_pin(sclk_o),
        .o_serial_clock_pin_oe_n(sclk_oe_n), .i_mosi(mosi_w),
        .o_mosi(mosi_o), .o_mosi_oe_n(mosi_oe_n), .i_miso(miso_w),
        .o_miso(miso_o), .o_miso_oe_n(miso_oe_n),
        .i_slave_select_in_n(ss_n), .i_tx_valid(tx_valid),
        .i_tx_data(tx_data), .o_tx_ready(tx_ready),
        .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_busy(busy),
        .o_mm_error(mm_err), .i_mm_error_clr(clr));

    spp_peer spp_peer_inst (
        .i_sclk(sclk_w), .i_mosi(mosi_w), .i_miso(miso_w),
        .i_cpol(ctrl.cpol), .i_cpha(ctrl.cpha), .o_miso(p_miso),
        .o_miso_en(p_miso_en), .o_sclk(p_sclk), .o_sclk_en(p_sclk_en),
        .o_mosi(p_mosi), .o_mosi_en(p_mosi_en), .o_ss_n(ss_n));

    // Clock, edge and word counters, and a guard against a hang.
    initial begin
        i_clk_sys = 1'b0;
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end
    always @(sclk_w) edges++;
    always @(posedge i_clk_sys) begin
        if (rx_valid === 1'b1) rxcnt++;
        cycles++;
        if (cycles == 20000) begin
            fails++;
            end_of_test();
        end
    end

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, g, e);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask : cyc

    // The source holds the word until ready is seen before an edge.
    task automatic wr(input spp_pkg::spp_word_t w);
        @(posedge i_clk_sys);
        tx_valid <= 1'b1;
        tx_data  <= w;
        do @(negedge i_clk_sys); while (tx_ready !== 1'b1);
        @(posedge i_clk_sys);
        tx_valid <= 1'b0;
    endtask : wr

    task automatic wait_rx();
        int n;
        n = 0;
        do begin
            @(posedge i_clk_sys);
            #1;
            n++;
        end while (rx_valid !== 1'b1 && n < 300);
        chk({7'h0, rx_valid}, 8'h01);
    endtask : wait_rx

    task automatic setc(input logic ms, pol, pha, od_b, sod_b);
        @(posedge i_clk_sys);
        ctrl <= '{8'h03, sod_b, od_b, pha, pol, ms, 1'b1};
    endtask : setc

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    // Reset pins, four master formats, contention, then slave drive modes.
    initial begin
        ctrl = '0;
        boot = 2'h1;
        {tx_valid, clr, tx_data, i_resetn, exp_oe} = '0;
        cyc(6);
        #1 chk(pins, 8'h03);
        @(posedge i_clk_sys) i_resetn <= 1'b1;
        cyc(3);
        for (int m = 0; m < 4; m++) begin
            setc(1'b1, m[1], m[0], 1'b0, 1'b0);
            cyc(6);
            chk({7'h0, sclk_w}, {7'h0, m[1]});
            edges = 0;
            spp_peer_inst.arm(~mw[m]);
            wr(mw[m]);
            wait_rx();
            spp_peer_inst.disarm();
            chk(rx_data, ~mw[m]);
            chk(spp_peer_inst.rx, mw[m]);
            cyc(6);
            chk(8'(edges), 8'h10);
            chk({6'h0, sclk_w, busy}, {6'h0, m[1], 1'b0});
        end
        // Contention holds the queue: fill it until it refuses.
        spp_peer_inst.sel(1'b0);
        cyc(8);
        chk({6'h0, mm_err, sclk_oe_n}, 8'h03);
        for (int i = 0; i < 4; i++) wr(8'(8'h10 + i));
        @(posedge i_clk_sys) tx_valid <= 1'b1;
        cyc(3);
        @(negedge i_clk_sys) chk({7'h0, tx_ready}, 8'h00);
        @(posedge i_clk_sys) tx_valid <= 1'b0;
        spp_peer_inst.sel(1'b1);
        cyc(4);
        @(posedge i_clk_sys) clr <= 1'b1;
        @(posedge i_clk_sys) clr <= 1'b0;
        rxcnt = 0;
        cyc(400);
        chk(8'(rxcnt), 8'h04);
        chk({6'h0, mm_err, busy}, 8'h00);
        setc(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        spp_peer_inst.xfer(8'hC3, got);
        chk(got, 8'hFF);
        chk(8'(rxcnt), 8'h04);
        for (int i = 0; i < 3; i++) begin
            setc(1'b0, 1'b0, 1'b0, od[i], sod[i]);
            wr(sw[i]);
            spp_peer_inst.sel(1'b0);
            cyc(20);
            exp_oe = sod[i] | (od[i] & sw[i][7]);
            chk({7'h0, miso_oe_n}, {7'h0, exp_oe});
            spp_peer_inst.xfer(8'(8'hC0 + i), got);
            cyc(10);
            spp_peer_inst.sel(1'b1);
            chk(got, sod[i] ? 8'hFF : sw[i]);
            chk(rx_data, 8'(8'hC0 + i));
        end
        @(posedge i_clk_sys) boot <= 2'h0;
        cyc(4);
        @(posedge i_clk_sys) i_resetn <= 1'b0;
        cyc(3);
        #1 chk(pins & 8'h15, 8'h15);
        end_of_test();
    end
endmodule : spp_port_tb
`default_nettype wire
